// ---- lcas_pkg.sv ----
// lcas_pkg: shared constants, field layouts and types for the alarm block
package lcas_pkg;

    // channel count and register-port geometry
    localparam int unsigned NUM_CHANNELS = 12;
    localparam int unsigned ADDR_WIDTH   = 8;
    localparam int unsigned DATA_WIDTH   = 8;

    // register offsets inside one channel page (low address nibble)
    localparam logic [3:0] REG_ALARM_STATUS     = 4'h3;
    localparam logic [3:0] REG_TRANSMIT_CONTROL = 4'h4;

    // channel_alarm_status field positions
    localparam int unsigned AS_DMO_BIT        = 0;
    localparam int unsigned AS_LOS_BIT        = 1;
    localparam int unsigned AS_LOL_BIT        = 2;
    localparam int unsigned AS_ANALOG_LOS_BIT = 4;

    // transmit_control field positions, writable mask and reset value
    localparam int unsigned TC_LEVEL_BIT    = 0;
    localparam int unsigned TC_CLK_INV_BIT  = 1;
    localparam int unsigned TC_ALL_ONES_BIT = 2;
    localparam int unsigned TC_ERR_INS_BIT  = 4;
    localparam int unsigned TC_MON_SRC_BIT  = 5;
    localparam logic [7:0]  TC_WRITE_MASK   = 8'h37;
    localparam logic [7:0]  TC_RESET        = 8'h00;

    // drive monitor: bit periods without a pulse before the alarm
    localparam int unsigned DMO_IDLE_BITS = 128;

    // loss of lock: deviation in ppm, window of reference edges
    localparam int unsigned LOL_PPM    = 5000;
    localparam int unsigned LOL_WINDOW = 2000;
    localparam int unsigned LOL_LIMIT  = LOL_WINDOW * LOL_PPM / 1000000;

    // live alarms of one channel
    typedef struct packed {
        logic clock_lock_lost;
        logic signal_lost;
        logic drive_monitor_alarm;
    } lcas_alarm_type;

    // page nibble to channel: pages 0-5 and 8-D; {valid, index}
    function automatic logic [4:0] lcas_decode_chan(input logic [3:0] page);
        logic [4:0] res;
        res = 5'h00;
        if (page <= 4'h5)
            res = {1'b1, page};
        else if (page >= 4'h8 && page <= 4'hD)
            res = {1'b1, page - 4'h2};
        return res;
    endfunction

    // assemble the status byte; unlisted bits read as zero
    function automatic logic [7:0] lcas_status_word(
        input lcas_alarm_type al,
        input logic           analog_los
    );
        logic [7:0] w;
        w = 8'h00;
        w[AS_DMO_BIT]        = al.drive_monitor_alarm;
        w[AS_LOS_BIT]        = al.signal_lost;
        w[AS_LOL_BIT]        = al.clock_lock_lost;
        w[AS_ANALOG_LOS_BIT] = analog_los;
        return w;
    endfunction

endpackage

// ---- lcas_lock_detect.sv ----
// lcas_lock_detect: recovered versus reference clock frequency comparator
module lcas_lock_detect #(
    parameter int unsigned WINDOW = lcas_pkg::LOL_WINDOW,
    parameter int unsigned LIMIT  = lcas_pkg::LOL_LIMIT
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic rec_clk_i,
    input  wire logic ref_clk_i,
    output logic      lock_lost_o
);
    logic        rec_prev_reg;
    logic        ref_prev_reg;
    logic [15:0] ref_cnt_reg;
    logic [15:0] rec_cnt_reg;
    logic        lost_reg;

    // edge detection on the sampled clock levels
    wire logic        rec_rise   = rec_clk_i & ~rec_prev_reg;
    wire logic        ref_rise   = ref_clk_i & ~ref_prev_reg;
    wire logic        window_end = ref_rise &&
                                   (ref_cnt_reg == 16'(WINDOW - 1));
    wire logic [15:0] rec_total  = rec_cnt_reg + 16'(rec_rise);
    wire logic [15:0] diff       = (rec_total >= 16'(WINDOW)) ?
                                   rec_total - 16'(WINDOW) :
                                   16'(WINDOW) - rec_total;
    wire logic        big_diff   = diff >= 16'(LIMIT);

    // verdict only at window end, so a slow drift cannot flicker the flag
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rec_prev_reg <= 1'b0;
            ref_prev_reg <= 1'b0;
            ref_cnt_reg  <= 16'h0000;
            rec_cnt_reg  <= 16'h0000;
            lost_reg     <= 1'b0;
        end
        else
        begin
            rec_prev_reg <= rec_clk_i;
            ref_prev_reg <= ref_clk_i;
            if (window_end)
            begin
                ref_cnt_reg <= 16'h0000;
                rec_cnt_reg <= 16'h0000;
                lost_reg    <= big_diff;
            end
            else
            begin
                ref_cnt_reg <= ref_cnt_reg + 16'(ref_rise);
                rec_cnt_reg <= rec_total;
            end
        end
    end

    assign lock_lost_o = lost_reg;

    // verdict follows the comparison taken at the end of each window
    a_lol_verdict: assert property (@(posedge clk_i)
        disable iff (rst_i)
        window_end |=> (lock_lost_o == $past(big_diff)))
        else $error("lock flag does not match window comparison");

    // between window ends the flag holds still
    a_lol_holds: assert property (@(posedge clk_i) disable iff (rst_i)
        !window_end |=> $stable(lock_lost_o))
        else $error("lock flag moved outside a window end");
endmodule

// ---- lcas_drive_monitor.sv ----
// lcas_drive_monitor: transmit line activity watchdog for one channel
module lcas_drive_monitor #(
    parameter int unsigned IDLE_BITS = lcas_pkg::DMO_IDLE_BITS
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic bit_tick_i,
    input  wire logic src_internal_i,
    input  wire logic tx_line_pos_i,
    input  wire logic tx_line_neg_i,
    input  wire logic monitor_in_pos_i,
    input  wire logic monitor_in_neg_i,
    output logic      alarm_o
);
    logic [15:0] idle_cnt_reg;
    logic        alarm_reg;

    // sense point: pads when internal, monitor pins when external
    wire logic sense_pos = src_internal_i ? tx_line_pos_i
                                          : monitor_in_pos_i;
    wire logic sense_neg = src_internal_i ? tx_line_neg_i
                                          : monitor_in_neg_i;
    wire logic pulse     = sense_pos | sense_neg;
    wire logic last_idle = idle_cnt_reg == 16'(IDLE_BITS - 1);

    // count quiet bit periods; a pulse sensed at a bit tick restarts the count
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            idle_cnt_reg <= 16'h0000;
            alarm_reg    <= 1'b0;
        end
        else if (bit_tick_i)
        begin
            if (pulse)
            begin
                idle_cnt_reg <= 16'h0000;
                alarm_reg    <= 1'b0;
            end
            else if (last_idle)
                alarm_reg    <= 1'b1;
            else
                idle_cnt_reg <= idle_cnt_reg + 16'h0001;
        end
    end

    assign alarm_o = alarm_reg;

    sequence s_quiet_last;
        bit_tick_i && !pulse && last_idle;
    endsequence

    // the alarm is raised only after the full quiet run
    a_dmo_declare: assert property (@(posedge clk_i)
        disable iff (rst_i)
        $rose(alarm_o) |-> $past(last_idle) && $past(bit_tick_i))
        else $error("drive alarm raised before quiet run ended");

    a_dmo_reach: assert property (@(posedge clk_i) disable iff (rst_i)
        s_quiet_last |=> alarm_o)
        else $error("drive alarm missing after quiet run");

    // one sensed pulse clears it on the next cycle
    a_dmo_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        (bit_tick_i && pulse) |=> !alarm_o && idle_cnt_reg == 16'h0000)
        else $error("drive alarm not cleared by activity");
endmodule

// ---- lcas_alarm_top.sv ----
// lcas_alarm_top: per-channel alarm status and transmit control registers
//
// Contract
// - loss of lock at 0.5% clock deviation
// - status bit 2 shows loss of lock
// - DS3/STS-1: signal lost if digital or analog
// - E3: signal lost from G.775 detector
// - status bit 1 shows signal lost
// - drive alarm after 128 quiet bit periods
// - drive alarm clears on bipolar activity
// - drive sensing internal pads or monitor pins
// - status bit 0 shows drive alarm
// - transmit control fields per channel, reserved zero
// - source bit: 0 external, 1 internal
// - error bit rising edge injects one error
module lcas_alarm_top #(
    parameter int unsigned CHANNELS      = lcas_pkg::NUM_CHANNELS,
    parameter int unsigned LOL_WINDOW    = lcas_pkg::LOL_WINDOW,
    parameter int unsigned LOL_LIMIT     = lcas_pkg::LOL_LIMIT,
    parameter int unsigned DMO_IDLE_BITS = lcas_pkg::DMO_IDLE_BITS
) (
    input  wire logic                 SYS_CLK_I,
    input  wire logic                 SYS_RST_I,
    input  wire logic [7:0]           ADDR_I,
    input  wire logic [7:0]           WR_DATA_I,
    input  wire logic                 WR_I,
    input  wire logic                 RD_I,
    output logic      [7:0]           RD_DATA_O,
    input  wire logic [CHANNELS-1:0]  REC_CLK_I,
    input  wire logic [CHANNELS-1:0]  REF_CLK_I,
    input  wire logic [CHANNELS-1:0]  E3_MODE_I,
    input  wire logic [CHANNELS-1:0]  DIGITAL_LOS_I,
    input  wire logic [CHANNELS-1:0]  ANALOG_LOS_I,
    input  wire logic [CHANNELS-1:0]  G775_LOS_I,
    input  wire logic [CHANNELS-1:0]  TX_BIT_TICK_I,
    input  wire logic [CHANNELS-1:0]  TX_LINE_POS_I,
    input  wire logic [CHANNELS-1:0]  TX_LINE_NEG_I,
    input  wire logic [CHANNELS-1:0]  MONITOR_IN_POS_I,
    input  wire logic [CHANNELS-1:0]  MONITOR_IN_NEG_I,
    output logic      [CHANNELS-1:0]  TX_ALL_ONES_O,
    output logic      [CHANNELS-1:0]  TX_CLOCK_INVERT_O,
    output logic      [CHANNELS-1:0]  TX_LEVEL_SELECT_O,
    output logic      [CHANNELS-1:0]  ERR_INSERT_O
);
    logic [7:0]             tc_reg [CHANNELS];
    logic [CHANNELS-1:0]    los_reg;
    logic [CHANNELS-1:0]    err_reg;
    logic [7:0]             rd_data_reg;
    logic [CHANNELS-1:0]    clock_lock_lost;
    logic [CHANNELS-1:0]    drive_monitor_alarm;
    logic [CHANNELS-1:0]    wr_sel;
    logic [7:0]             status_word [CHANNELS];
    lcas_pkg::lcas_alarm_type alarm [CHANNELS];

    // address decode: high nibble picks the channel page, low the register
    wire logic [4:0] dec        = lcas_pkg::lcas_decode_chan(ADDR_I[7:4]);
    wire logic       chan_ok    = dec[4] && (32'(dec[3:0]) < CHANNELS);
    wire logic [3:0] chan_idx   = dec[3:0];
    wire logic       hit_status = chan_ok &&
                                  ADDR_I[3:0] == lcas_pkg::REG_ALARM_STATUS;
    wire logic       hit_tc     = chan_ok &&
                                  ADDR_I[3:0] == lcas_pkg::REG_TRANSMIT_CONTROL;
    wire logic       wr_tc      = WR_I && hit_tc;

    // read selection; unmapped addresses return zero
    wire logic [7:0] rd_value = hit_status ? status_word[chan_idx] :
                                hit_tc     ? tc_reg[chan_idx]      :
                                             8'h00;

    // read port: a read only samples, it clears nothing
    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
            rd_data_reg <= 8'h00;
        else if (RD_I)
            rd_data_reg <= rd_value;
    end

    assign RD_DATA_O = rd_data_reg;

    genvar c;
    generate
        for (c = 0; c < CHANNELS; c++)
        begin : g_chan
            wire logic [7:0] tc_write = WR_DATA_I & lcas_pkg::TC_WRITE_MASK;
            wire logic       err_bit  = WR_DATA_I[lcas_pkg::TC_ERR_INS_BIT];
            wire logic       err_old  = tc_reg[c][lcas_pkg::TC_ERR_INS_BIT];
            // monitor source: 1 senses the pads, 0 the monitor pins
            wire logic       mon_int  =
                tc_reg[c][lcas_pkg::TC_MON_SRC_BIT];
            // signal-loss combination depends on the line standard
            wire logic       los_next = E3_MODE_I[c] ? G775_LOS_I[c]
                                        : (DIGITAL_LOS_I[c] |
                                           ANALOG_LOS_I[c]);

            assign wr_sel[c] = wr_tc && chan_idx == 4'(c);

            // control register; reserved bits are masked so they read zero
            always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I)
            begin
                if (SYS_RST_I)
                    tc_reg[c] <= lcas_pkg::TC_RESET;
                else if (wr_sel[c])
                    tc_reg[c] <= tc_write;
            end

            // error pulse only on a 0-to-1 write; rewriting 1 does nothing
            always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I)
            begin
                if (SYS_RST_I)
                    err_reg[c] <= 1'b0;
                else
                    err_reg[c] <= wr_sel[c] && err_bit && !err_old;
            end

            // registered so the status byte never sees a glitching OR
            always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I)
            begin
                if (SYS_RST_I)
                    los_reg[c] <= 1'b0;
                else
                    los_reg[c] <= los_next;
            end

            lcas_lock_detect #(
                .WINDOW (LOL_WINDOW),
                .LIMIT  (LOL_LIMIT)
            ) u_lock (
                .clk_i       (SYS_CLK_I),
                .rst_i       (SYS_RST_I),
                .rec_clk_i   (REC_CLK_I[c]),
                .ref_clk_i   (REF_CLK_I[c]),
                .lock_lost_o (clock_lock_lost[c])
            );

            // source select: 1 internal pads, 0 external monitor pins
            lcas_drive_monitor #(
                .IDLE_BITS (DMO_IDLE_BITS)
            ) u_dmon (
                .clk_i            (SYS_CLK_I),
                .rst_i            (SYS_RST_I),
                .bit_tick_i       (TX_BIT_TICK_I[c]),
                .src_internal_i   (mon_int),
                .tx_line_pos_i    (TX_LINE_POS_I[c]),
                .tx_line_neg_i    (TX_LINE_NEG_I[c]),
                .monitor_in_pos_i (MONITOR_IN_POS_I[c]),
                .monitor_in_neg_i (MONITOR_IN_NEG_I[c]),
                .alarm_o          (drive_monitor_alarm[c])
            );

            // status byte built from the live alarm state
            assign alarm[c].clock_lock_lost = clock_lock_lost[c];
            assign alarm[c].signal_lost = los_reg[c];
            assign alarm[c].drive_monitor_alarm = drive_monitor_alarm[c];
            assign status_word[c] = lcas_pkg::lcas_status_word(alarm[c],
                                        ANALOG_LOS_I[c]);

            assign TX_ALL_ONES_O[c]     = tc_reg[c][lcas_pkg::TC_ALL_ONES_BIT];
            assign TX_CLOCK_INVERT_O[c] = tc_reg[c][lcas_pkg::TC_CLK_INV_BIT];
            assign TX_LEVEL_SELECT_O[c] = tc_reg[c][lcas_pkg::TC_LEVEL_BIT];
            assign ERR_INSERT_O[c]      = err_reg[c];

            // in E3 the signal-lost bit ignores the DS3 detectors
            a_los_e3: assert property (@(posedge SYS_CLK_I)
                disable iff (SYS_RST_I)
                E3_MODE_I[c] |=> los_reg[c] == $past(G775_LOS_I[c]))
                else $error("E3 signal loss not from G.775 detector");

            a_los_ds3: assert property (@(posedge SYS_CLK_I)
                disable iff (SYS_RST_I)
                !E3_MODE_I[c] |=> los_reg[c] ==
                    ($past(DIGITAL_LOS_I[c]) || $past(ANALOG_LOS_I[c])))
                else $error("DS3 signal loss not digital or analog");

            // a rising write gives exactly one pulse, then silence
            a_err_once: assert property (@(posedge SYS_CLK_I)
                disable iff (SYS_RST_I)
                (wr_sel[c] && err_bit && !err_old) |=>
                    ERR_INSERT_O[c] ##1 !ERR_INSERT_O[c])
                else $error("error insert not a single pulse");

            a_err_cause: assert property (@(posedge SYS_CLK_I)
                disable iff (SYS_RST_I)
                ERR_INSERT_O[c] |-> $past(wr_sel[c]) &&
                    tc_reg[c][lcas_pkg::TC_ERR_INS_BIT] &&
                    !$past(err_old))
                else $error("error pulse without rising write");

            a_tc_reserved: assert property (@(posedge SYS_CLK_I)
                disable iff (SYS_RST_I)
                (tc_reg[c] & ~lcas_pkg::TC_WRITE_MASK) == 8'h00)
                else $error("reserved control bits not zero");
        end
    endgenerate

    // status read returns the alarm state of the addressed channel
    a_status_read: assert property (@(posedge SYS_CLK_I)
        disable iff (SYS_RST_I)
        (RD_I && hit_status) |=>
            RD_DATA_O[lcas_pkg::AS_LOL_BIT] == $past(clock_lock_lost[chan_idx]) &&
            RD_DATA_O[lcas_pkg::AS_LOS_BIT] == $past(los_reg[chan_idx]) &&
            RD_DATA_O[lcas_pkg::AS_DMO_BIT] == $past(drive_monitor_alarm[chan_idx]))
        else $error("status read does not show alarm state");

    // a read leaves the channel 0 control register alone unless it is written
    a_read_no_effect: assert property (@(posedge SYS_CLK_I)
        disable iff (SYS_RST_I)
        (RD_I && $stable(los_reg)) |=> $stable(tc_reg[0]) || $past(wr_sel[0]))
        else $error("read disturbed register state");

    a_unmapped_zero: assert property (@(posedge SYS_CLK_I)
        disable iff (SYS_RST_I)
        (RD_I && !hit_status && !hit_tc) |=> RD_DATA_O == 8'h00)
        else $error("unmapped read not zero");
endmodule

// ---- lcas_alarm_top_tb_top.sv ----
// lcas_alarm_top_tb_top: self-checking bench for the alarm status block
module lcas_alarm_top_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    // {e3, digital, analog, g775} steps and the status byte each must give
    localparam logic [3:0] LOS_CFG [6] = '{4'hC, 4'h9, 4'h1, 4'h4, 4'h2, 4'hA};
    localparam logic [7:0] LOS_EXP [6] = '{8'h00, 8'h02, 8'h00, 8'h02,
                                           8'h12, 8'h10};

    logic        sys_clk, sys_rst, wr, rd;
    logic [7:0]  addr, wr_data, rd_data;
    logic [11:0] rec_clk, ref_clk, e3_mode, dig_los, ana_los, g775_los;
    logic [11:0] bit_tick, tx_pos, tx_neg, mon_pos, mon_neg;
    logic [11:0] all_ones, clk_inv, lev_sel, err_ins;
    logic [11:0] exp_aos, exp_inv, exp_lev;
    int          err_total   = 0;
    int          check_count = 0;
    int          ref_cnt     = 0;
    int          rec_cnt     = 0;
    int          rec_half    = 2;

    // window of 400 reference edges keeps a one-edge phase slip below 0.5%
    lcas_alarm_top #(.LOL_WINDOW(400), .LOL_LIMIT(2)) DUT (
        .SYS_CLK_I(sys_clk), .SYS_RST_I(sys_rst), .ADDR_I(addr),
        .WR_DATA_I(wr_data), .WR_I(wr), .RD_I(rd), .RD_DATA_O(rd_data),
        .REC_CLK_I(rec_clk), .REF_CLK_I(ref_clk), .E3_MODE_I(e3_mode),
        .DIGITAL_LOS_I(dig_los), .ANALOG_LOS_I(ana_los),
        .G775_LOS_I(g775_los), .TX_BIT_TICK_I(bit_tick),
        .TX_LINE_POS_I(tx_pos), .TX_LINE_NEG_I(tx_neg),
        .MONITOR_IN_POS_I(mon_pos), .MONITOR_IN_NEG_I(mon_neg),
        .TX_ALL_ONES_O(all_ones), .TX_CLOCK_INVERT_O(clk_inv),
        .TX_LEVEL_SELECT_O(lev_sel), .ERR_INSERT_O(err_ins)
    );

    // 250 MHz system clock
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // line clocks for all channels; rec_half skews the recovered rate
    always @(posedge sys_clk)
    begin
        #1;
        ref_cnt = (ref_cnt + 1) % 2;
        rec_cnt = (rec_cnt + 1) % rec_half;
        if (ref_cnt == 0) ref_clk = ~ref_clk;
        if (rec_cnt == 0) rec_clk = ~rec_clk;
    end

    function automatic logic [7:0] adr(input int ch, input logic [3:0] r);
        logic [3:0] pg;
        pg = (ch < 6) ? 4'(ch) : 4'(ch + 2);
        return {pg, r};
    endfunction

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk) #1;
        addr = a;
        wr_data = d;
        wr = 1'b1;
        @(posedge sys_clk) #1;
        wr = 1'b0;
    endtask

    // read data is registered: look just after the edge that takes the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk) #1;
        addr = a;
        rd = 1'b1;
        @(posedge sys_clk) #1;
        rd = 1'b0;
        chk({4'h0, rd_data}, {4'h0, exp});
    endtask

    // n bit ticks on channel 3; lv = {pad pos, pad neg, mon pos, mon neg}
    task automatic tk(input int n, input logic [3:0] lv);
        repeat (n)
        begin
            @(posedge sys_clk) #1;
            bit_tick[3] = 1'b1;
            {tx_pos[3], tx_neg[3], mon_pos[3], mon_neg[3]} = lv;
            @(posedge sys_clk) #1;
            bit_tick[3] = 1'b0;
            {tx_pos[3], tx_neg[3], mon_pos[3], mon_neg[3]} = 4'h0;
        end
    endtask

    task automatic t_reset;
        for (int ch = 0; ch < 12; ch++)
        begin
            rd_chk(adr(ch, 4'h4), 8'h00);
            rd_chk(adr(ch, 4'h3), 8'h00);
        end
    endtask

    task automatic t_control;
        for (int ch = 0; ch < 12; ch++)
        begin
            wr_reg(adr(ch, 4'h4), {5'h00, 3'(ch)});
            {exp_aos[ch], exp_inv[ch], exp_lev[ch]} = 3'(ch);
        end
        chk(all_ones, exp_aos);
        chk(clk_inv, exp_inv);
        chk(lev_sel, exp_lev);
        for (int ch = 0; ch < 12; ch++)
            rd_chk(adr(ch, 4'h4), {5'h00, 3'(ch)});
        wr_reg(adr(2, 4'h4), 8'hFF);
        rd_chk(adr(2, 4'h4), 8'h37);
        chk(all_ones, exp_aos | 12'h004);
        // unmapped page, unmapped register, and the read-only status byte
        wr_reg(8'h64, 8'h37);
        rd_chk(8'h64, 8'h00);
        rd_chk(8'h05, 8'h00);
        wr_reg(adr(0, 4'h3), 8'hFF);
        rd_chk(adr(0, 4'h3), 8'h00);
    endtask

    task automatic t_err;
        wr_reg(adr(6, 4'h4), 8'h00);
        wr_reg(adr(6, 4'h4), 8'h10);
        chk(err_ins, 12'h040);
        @(posedge sys_clk) #1;
        chk(err_ins, 12'h000);
        wr_reg(adr(6, 4'h4), 8'h10);
        chk(err_ins, 12'h000);
    endtask

    task automatic t_los;
        for (int i = 0; i < 6; i++)
        begin
            @(posedge sys_clk) #1;
            {e3_mode[7], dig_los[7], ana_los[7], g775_los[7]} = LOS_CFG[i];
            repeat (2) @(posedge sys_clk);
            rd_chk(adr(7, 4'h3), LOS_EXP[i]);
            rd_chk(adr(7, 4'h3), LOS_EXP[i]);
        end
        {e3_mode[7], dig_los[7], ana_los[7], g775_los[7]} = 4'h0;
    endtask

    task automatic t_drive;
        wr_reg(adr(3, 4'h4), 8'h00);
        tk(127, 4'h0);
        rd_chk(adr(3, 4'h3), 8'h00);
        tk(1, 4'h0);
        rd_chk(adr(3, 4'h3), 8'h01);
        // pad pulses must not count while the monitor pins are selected
        tk(3, 4'hC);
        rd_chk(adr(3, 4'h3), 8'h01);
        tk(1, 4'h1);
        rd_chk(adr(3, 4'h3), 8'h00);
        wr_reg(adr(3, 4'h4), 8'h20);
        tk(128, 4'h3);
        rd_chk(adr(3, 4'h3), 8'h01);
        tk(1, 4'h4);
        rd_chk(adr(3, 4'h3), 8'h00);
    endtask

    task automatic t_lock;
        rec_half = 3;
        repeat (3600) @(posedge sys_clk);
        rd_chk(adr(0, 4'h3), 8'h04);
        rd_chk(adr(11, 4'h3), 8'h04);
        rec_half = 2;
        repeat (3600) @(posedge sys_clk);
        rd_chk(adr(11, 4'h3), 8'h00);
    endtask

    task automatic close_out;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // main sequence: quiet inputs, six-cycle reset, then the scenarios
    initial
    begin
        {wr, rd, addr, wr_data} = '0;
        {rec_clk, ref_clk, e3_mode, dig_los, ana_los, g775_los} = '0;
        {bit_tick, tx_pos, tx_neg, mon_pos, mon_neg} = '0;
        sys_rst = 1'b1;
        repeat (6) @(posedge sys_clk);
        #1 sys_rst = 1'b0;
        t_reset();
        t_control();
        t_err();
        t_los();
        t_drive();
        t_lock();
        close_out();
    end

    // the scenarios need about 8k cycles; cut a hang at 25k
    initial
    begin
        #100000;
        err_total++;
        $display("[ERR] %0t watchdog expired", $time);
        close_out();
    end
endmodule
